// ==== sid_defs.svh ====
// Offsets, field values and sizes of the station-identification server
`ifndef SID_DEFS_SVH
`define SID_DEFS_SVH

// Identification block word indexes (word address on the bus = index)
`define SID_IDX_TAG 9'h01c
`define SID_IDX_REV_KIND 9'h01e
`define SID_IDX_VERSION 9'h020
`define SID_IDX_PATCH 9'h022
`define SID_IDX_FUNC_KIND 9'h024
`define SID_IDX_FUNC_FLAGS 9'h026
`define SID_IDX_KIND_LO 9'h028
`define SID_IDX_ID_SIZE 9'h02a
`define SID_IDX_ID_W0 9'h02c
`define SID_IDX_ID_W1 9'h02e
`define SID_IDX_ID_W2 9'h030
`define SID_IDX_DEV_KIND 9'h032
`define SID_IDX_DEV_FIELD 9'h034
`define SID_IDX_EXTRA_FIRST 9'h036
`define SID_IDX_EXTRA_LAST 9'h0c6

// Command block and control registers
`define SID_IDX_CMD 9'h100
`define SID_IDX_BOOT_W0 9'h101
`define SID_IDX_BOOT_W1 9'h102
`define SID_IDX_BOOT_W2 9'h103
`define SID_IDX_LIST_SIZE 9'h104
`define SID_IDX_STATUS 9'h105

// Fixed identification field values
`define SID_PROTO_REV_KIND 16'h0001
`define SID_PROTO_MAJOR 8'h03
`define SID_PROTO_VERSION_SIZE 8'h03
`define SID_PROTO_USER_PATCH 8'h00
`define SID_PROTO_PATCH 8'h00
`define SID_FUNCTION_KIND 16'h0002
`define SID_FLAGS_A_BOOT 8'h15
`define SID_FLAGS_A_NOBOOT 8'h05
`define SID_FUNCTION_FIELD_SIZE 8'h02
`define SID_FUNCTION_FLAGS_B 8'h00
`define SID_STATION_KIND_LO 8'h07
`define SID_STATION_KIND_HI 8'h00
`define SID_STATION_ID_SIZE 8'h06
`define SID_DEVICE_FIELD_SIZE 8'h01

// Extra parameter area
`define SID_EXTRA_MAX_BYTES 8'h92
`define SID_EXTRA_WORDS 73

// Command opcodes and field positions
`define SID_OP_READ_BOOT 8'h18
`define SID_OP_WRITE_BOOT 8'h19
`define SID_STAT_ERR_BIT 0
`define SID_STAT_BUSY_BIT 1
`define SID_STAT_BOOTEN_BIT 2

`endif

// ==== sid_pkg.sv ====
// Types of the station-identification server
package sid_pkg;

  typedef enum logic [1:0] {
    SID_IDLE = 2'b01,
    SID_SEND = 2'b10
  } sid_fsm_e;

  typedef struct packed {
    logic valid;
    logic last;
    logic one_byte;
    logic [15:0] word;
  } sid_frame_s;

  typedef struct packed {
    logic load_start;
    logic [47:0] source;
  } sid_boot_s;

  typedef struct packed {
    logic ack;
    logic waitreq;
    logic [31:0] rdata;
    logic [15:0] cmd_word;
    logic [47:0] pcb_addr;
    logic [47:0] boot_addr;
    logic [7:0] list_size;
    logic cmd_err;
    logic [72:0][15:0] extra;
    sid_fsm_e fsm;
    logic [8:0] fidx;
    logic [7:0] left;
    logic odd;
    logic [15:0] tag_hold;
    sid_frame_s frame;
    sid_boot_s boot;
  } sid_state_s;

endpackage

// ==== sid_server.sv ====
// Station-identification parameter block, frame builder and boot server address
//
// How it works
// - Reply frames carry the requesting node's receipt tag.
// - Host reads of the receipt tag field always return zero.
// - Word o36 holds protocol revision kind 1.
// - Word o40 holds protocol major 3 high, version size 3 low.
// - Word o42 holds user patch 0 high, patch 0 low.
// - Word o44 holds function kind 2.
// - Flags byte A is 0x15 with remote boot allowed, else 5.
// - Low byte of word o46 holds function field size 2.
// - Flags byte B is 0 in low byte of word o50.
// - Station id kind code 7 split: low in o50 high, high in o52 low.
// - Station id size 6 in high byte of word o52.
// - Factory 48-bit station id as three words, least significant first.
// - Device kind code at word o62, fixed, not host writable.
// - Word o64 holds device value high and device field size 1 low.
// - Frame appends exactly list-size extra bytes, at most 146.
// - Host writes leave all fixed identification fields unchanged.
// - Boot address commands use opcode 24 read, 25 write, high byte zero.
// - Boot address carried low word first in three command words.
// - After reset the stored boot address is the group multicast address.
// - On a boot frame, loading starts from the stored boot address.
// - Unprompted frames carry receipt tag zero.
`timescale 1ns/1ps
`include "sid_defs.svh"

module sid_server #(
  parameter logic [47:0] BOOT_GROUP_ADDR = 48'h0000_0000_0001,
  // Arbitrary neutral identity values
  parameter logic [15:0] DEVICE_KIND = 16'h00a5,
  parameter logic [7:0] DEVICE_VALUE = 8'h3c
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic [8:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic remote_boot_en,
  input wire logic [47:0] station_id,
  input wire logic id_reply_req,
  input wire logic [15:0] id_reply_tag,
  input wire logic id_announce_req,
  input wire logic boot_frame_seen,
  output sid_pkg::sid_frame_s id_frame,
  output sid_pkg::sid_boot_s boot_load
);

  sid_pkg::sid_state_s s;
  sid_pkg::sid_state_s next_s;

  // Identification block word as seen by the host and by the frame builder
  function automatic logic [15:0] id_word(input logic [8:0] idx, input sid_pkg::sid_state_s st);
    logic [8:0] off;
    off = idx - `SID_IDX_EXTRA_FIRST;
    case (idx)
      `SID_IDX_TAG: id_word = 16'h0000;
      `SID_IDX_REV_KIND: id_word = `SID_PROTO_REV_KIND;
      `SID_IDX_VERSION: id_word = {`SID_PROTO_MAJOR, `SID_PROTO_VERSION_SIZE};
      `SID_IDX_PATCH: id_word = {`SID_PROTO_USER_PATCH, `SID_PROTO_PATCH};
      `SID_IDX_FUNC_KIND: id_word = `SID_FUNCTION_KIND;
      `SID_IDX_FUNC_FLAGS: id_word = {remote_boot_en ? `SID_FLAGS_A_BOOT : `SID_FLAGS_A_NOBOOT,
                                      `SID_FUNCTION_FIELD_SIZE};
      `SID_IDX_KIND_LO: id_word = {`SID_STATION_KIND_LO, `SID_FUNCTION_FLAGS_B};
      `SID_IDX_ID_SIZE: id_word = {`SID_STATION_ID_SIZE, `SID_STATION_KIND_HI};
      `SID_IDX_ID_W0: id_word = station_id[15:0];
      `SID_IDX_ID_W1: id_word = station_id[31:16];
      `SID_IDX_ID_W2: id_word = station_id[47:32];
      `SID_IDX_DEV_KIND: id_word = DEVICE_KIND;
      `SID_IDX_DEV_FIELD: id_word = {DEVICE_VALUE, `SID_DEVICE_FIELD_SIZE};
      default: begin
        if (idx >= `SID_IDX_EXTRA_FIRST && idx <= `SID_IDX_EXTRA_LAST && !idx[0]) begin
          id_word = st.extra[off[7:1]];
        end else begin
          id_word = 16'h0000;
        end
      end
    endcase
  endfunction

  // Host read mux over identification block and control registers
  function automatic logic [31:0] bus_word(input logic [8:0] idx, input sid_pkg::sid_state_s st);
    case (idx)
      `SID_IDX_CMD: bus_word = {16'h0000, st.cmd_word};
      `SID_IDX_BOOT_W0: bus_word = {16'h0000, st.pcb_addr[15:0]};
      `SID_IDX_BOOT_W1: bus_word = {16'h0000, st.pcb_addr[31:16]};
      `SID_IDX_BOOT_W2: bus_word = {16'h0000, st.pcb_addr[47:32]};
      `SID_IDX_LIST_SIZE: bus_word = {24'h000000, st.list_size};
      `SID_IDX_STATUS: begin
        bus_word = 32'h0000_0000;
        bus_word[`SID_STAT_ERR_BIT] = st.cmd_err;
        bus_word[`SID_STAT_BUSY_BIT] = (st.fsm == sid_pkg::SID_SEND);
        bus_word[`SID_STAT_BOOTEN_BIT] = remote_boot_en;
      end
      default: bus_word = {16'h0000, id_word(idx, st)};
    endcase
  endfunction

  logic [8:0] woff;
  logic in_extra;
  logic last_word;

  always_comb begin
    next_s = s;
    woff = avs_address - `SID_IDX_EXTRA_FIRST;
    in_extra = (s.fidx > `SID_IDX_DEV_FIELD);
    last_word = in_extra ? (s.left == 8'h01)
                         : (s.fidx == `SID_IDX_DEV_FIELD && s.left == 8'h00);

    // Bus slave: one wait cycle, then the answer; writes land at the answer edge
    next_s.ack = (avs_read || avs_write) && !s.ack;
    // Waitrequest kept in its own flop so the pin comes straight from a register
    next_s.waitreq = !next_s.ack;
    if ((avs_read || avs_write) && !s.ack) begin
      next_s.rdata = avs_read ? bus_word(avs_address, s) : 32'h0000_0000;
    end
    if (avs_write && s.ack) begin
      case (avs_address)
        `SID_IDX_CMD: begin
          next_s.cmd_word = avs_writedata[15:0];
          if (avs_writedata[15:8] != 8'h00) begin
            next_s.cmd_err = 1'b1;
          end else if (avs_writedata[7:0] == `SID_OP_READ_BOOT) begin
            next_s.pcb_addr = s.boot_addr;
          end else if (avs_writedata[7:0] == `SID_OP_WRITE_BOOT) begin
            next_s.boot_addr = s.pcb_addr;
          end else begin
            next_s.cmd_err = 1'b1;
          end
        end
        `SID_IDX_BOOT_W0: next_s.pcb_addr[15:0] = avs_writedata[15:0];
        `SID_IDX_BOOT_W1: next_s.pcb_addr[31:16] = avs_writedata[15:0];
        `SID_IDX_BOOT_W2: next_s.pcb_addr[47:32] = avs_writedata[15:0];
        `SID_IDX_LIST_SIZE: begin
          if (avs_writedata[31:8] != 24'h000000 || avs_writedata[7:0] > `SID_EXTRA_MAX_BYTES) begin
            next_s.list_size = `SID_EXTRA_MAX_BYTES;
          end else begin
            next_s.list_size = avs_writedata[7:0];
          end
        end
        `SID_IDX_STATUS: begin
          if (avs_writedata[`SID_STAT_ERR_BIT]) begin
            next_s.cmd_err = 1'b0;
          end
        end
        default: begin
          // only the extra area takes writes
          if (avs_address >= `SID_IDX_EXTRA_FIRST && avs_address <= `SID_IDX_EXTRA_LAST
              && !avs_address[0]) begin
            next_s.extra[woff[7:1]] = avs_writedata[15:0];
          end
        end
      endcase
    end

    next_s.boot.load_start = boot_frame_seen;
    if (boot_frame_seen) begin
      next_s.boot.source = s.boot_addr;
    end

    // Frame builder, one word per cycle
    next_s.frame = '0;
    case (s.fsm)
      sid_pkg::SID_IDLE: begin
        if (id_reply_req || id_announce_req) begin
          next_s.fsm = sid_pkg::SID_SEND;
          next_s.fidx = `SID_IDX_TAG;
          // word count of the extra bytes
          next_s.left = 8'(({1'b0, s.list_size} + 9'h001) >> 1);
          next_s.odd = s.list_size[0];
          next_s.tag_hold = id_reply_req ? id_reply_tag : 16'h0000;
        end
      end
      sid_pkg::SID_SEND: begin
        next_s.frame.valid = 1'b1;
        next_s.frame.word = (s.fidx == `SID_IDX_TAG) ? s.tag_hold : id_word(s.fidx, s);
        next_s.frame.last = last_word;
        next_s.frame.one_byte = last_word && in_extra && s.odd;
        next_s.fidx = s.fidx + 9'h002;
        if (in_extra) begin
          next_s.left = s.left - 8'h01;
        end
        if (last_word) begin
          next_s.fsm = sid_pkg::SID_IDLE;
        end
      end
      default: next_s.fsm = sid_pkg::SID_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      s <= '0;
      s.waitreq <= 1'b1;
      s.fsm <= sid_pkg::SID_IDLE;
      s.fidx <= `SID_IDX_TAG;
      s.boot_addr <= BOOT_GROUP_ADDR;
      s.boot.source <= BOOT_GROUP_ADDR;
    end else begin
      s <= next_s;
    end
  end

  assign avs_readdata = s.rdata;
  assign avs_waitrequest = s.waitreq;
  assign id_frame = s.frame;
  assign boot_load = s.boot;

endmodule

// ==== sid_server_assertions.sv ====
// Port checker of the station-identification server
`timescale 1ns/1ps
module sid_server_assertions (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic [8:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic remote_boot_en,
  input wire logic id_reply_req,
  input wire logic [15:0] id_reply_tag,
  input wire logic id_announce_req,
  input wire logic boot_frame_seen,
  input sid_pkg::sid_frame_s id_frame,
  input sid_pkg::sid_boot_s boot_load
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  wire logic rd = avs_read && !avs_waitrequest;
  AST_ANSWER: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("request not answered");
  AST_ONE_ACK: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low twice");
  AST_TAG_HIDDEN: assert property (rd && avs_address == 9'h01c |-> avs_readdata == 0)
    else $error("receipt tag readable");
  AST_REV_KIND: assert property (rd && avs_address == 9'h01e |-> avs_readdata == 1)
    else $error("revision kind wrong");
  AST_FLAGS: assert property (rd && avs_address == 9'h026 |-> avs_readdata[15:0] ==
    ($past(remote_boot_en) ? 16'h1502 : 16'h0502)) else $error("function flags wrong");
  AST_REPLY: assert property (id_reply_req && !id_frame.valid
    && !$past(id_reply_req || id_announce_req)
    |=> ##1 id_frame.valid && id_frame.word == $past(id_reply_tag, 2))
    else $error("reply tag lost");
  AST_UNPROMPTED: assert property (id_announce_req && !id_reply_req && !id_frame.valid
    && !$past(id_reply_req || id_announce_req) |=> ##1 id_frame.valid && id_frame.word == 0)
    else $error("unprompted tag not zero");
  AST_SECOND: assert property (id_frame.valid && !$past(id_frame.valid)
    |=> id_frame.valid && id_frame.word == 16'h0001) else $error("second word wrong");
  AST_BOOT: assert property (boot_frame_seen |=> boot_load.load_start)
    else $error("boot load not started");
  AST_CV_READ: cover property (rd);
  AST_CV_ODD_END: cover property (id_frame.valid && id_frame.last && id_frame.one_byte);
  AST_CV_BOOT: cover property (boot_load.load_start);
endmodule
bind sid_server sid_server_assertions u_sid_server_assertions (.*);

// ==== sid_node_model.sv ====
// Remote node model: id requests, announcements, boot frames, frame capture
`timescale 1ns/1ps
module sid_node_model (
  input wire logic clk_sys,
  input sid_pkg::sid_frame_s id_frame,
  output logic id_reply_req = 1'b0,
  output logic [15:0] id_reply_tag = 16'h0000,
  output logic id_announce_req = 1'b0,
  output logic boot_frame_seen = 1'b0
);
  logic [15:0] words [$];
  logic odd_end;
  // Kind 0 request, 1 announce, 2 boot frame; one cycle each
  task automatic pulse(input int kind, input logic [15:0] tag);
    @(posedge clk_sys);
    id_reply_req <= (kind == 0);
    id_announce_req <= (kind == 1);
    boot_frame_seen <= (kind == 2);
    id_reply_tag <= tag;
    @(posedge clk_sys);
    id_reply_req <= 1'b0;
    id_announce_req <= 1'b0;
    boot_frame_seen <= 1'b0;
    id_reply_tag <= ~tag;
  endtask
  always @(posedge clk_sys) begin
    if (id_frame.valid) begin
      words.push_back(id_frame.word);
      odd_end <= id_frame.one_byte;
    end
  end
endmodule

// ==== tb_top.sv ====
// Self-checking bench of the station-identification server
`timescale 1ns/1ps
`define CHK(n, e, s) begin cmp_count++; if ((e) !== (s)) begin failures++; \
  $display("wrong value %s: expected %h, seen %h", n, e, s); end end
module tb_top;
  localparam logic [47:0] GROUP = 48'h0000_0000_0001;
  logic clk_sys = 1'b0, resetn = 1'b0, avs_read = 1'b0, avs_write = 1'b0, remote_boot_en = 1'b1;
  logic id_reply_req, id_announce_req, boot_frame_seen, avs_waitrequest;
  logic [8:0] avs_address = 9'h000;
  logic [31:0] avs_writedata = 32'h0000_0000, avs_readdata;
  logic [47:0] station_id = 48'h0000_0000_0000, addr;
  logic [15:0] id_reply_tag, q, tag;
  sid_pkg::sid_frame_s id_frame;
  sid_pkg::sid_boot_s boot_load;
  int failures = 0, cmp_count = 0, seed = 30792, n;
  logic [8:0] ids [15] = '{9'h01c, 9'h01d, 9'h01e, 9'h020, 9'h022, 9'h024, 9'h026, 9'h028,
    9'h02a, 9'h02c, 9'h02e, 9'h030, 9'h032, 9'h034, 9'h107};
  sid_server #(.BOOT_GROUP_ADDR(GROUP)) u_sid_server (.*);
  sid_node_model u_sid_node_model (.*);
  always #2.5 clk_sys = ~clk_sys;
  function automatic logic [15:0] exp_word(input logic [8:0] a);
    case (a)
      9'h01e: return 16'h0001;
      9'h020: return 16'h0303;
      9'h024: return 16'h0002;
      9'h026: return remote_boot_en ? 16'h1502 : 16'h0502;
      9'h028: return 16'h0700;
      9'h02a: return 16'h0600;
      9'h02c: return station_id[15:0];
      9'h02e: return station_id[31:16];
      9'h030: return station_id[47:32];
      9'h032: return 16'h00a5;
      9'h034: return 16'h3c01;
      default: return 16'h0000;
    endcase
  endfunction
  task automatic bus(input logic wr, input logic [8:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    avs_address <= a;
    avs_writedata <= {16'h0000, d};
    avs_read <= !wr;
    avs_write <= wr;
    do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
    q = avs_readdata[15:0];
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic boot(input logic [47:0] e);
    u_sid_node_model.pulse(2, 16'h0000);
    @(negedge clk_sys);
    `CHK("load start", 1'b1, boot_load.load_start)
    `CHK("load source", e, boot_load.source)
  endtask
  task automatic frame(input int kind, input logic [7:0] len);
    int e;
    int frame_char_total;
    e = (len > 146) ? 146 : int'(len);
    tag = 16'($random(seed));
    bus(1, 9'h036, ~tag);
    bus(1, 9'h104, {8'h00, len});
    bus(0, 9'h104, 16'h0000);
    `CHK("list size", e[15:0], q)
    u_sid_node_model.words.delete();
    u_sid_node_model.pulse(kind, tag);
    n = 0;
    do begin
      bus(0, 9'h105, 16'h0000);
      n++;
    end while (q[1] !== 1'b0 && n < 100);
    `CHK("frame done", 1'b0, q[1])
    `CHK("word count", 13 + (e + 1) / 2, u_sid_node_model.words.size())
    `CHK("extra word", ~tag, u_sid_node_model.words[13])
    `CHK("odd end", e[0], u_sid_node_model.odd_end)
    frame_char_total = 28 + 2 * (u_sid_node_model.words.size() - 13);
    frame_char_total = frame_char_total - int'(u_sid_node_model.odd_end);
    `CHK("char total", 28 + e, frame_char_total)
  endtask
  task automatic results;
    if (failures == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    #100000;
    failures++;
    results();
  end
  initial begin
    station_id <= 48'({$random(seed), $random(seed)});
    repeat (5) @(posedge clk_sys);
    resetn <= 1'b1;
    bus(1, 9'h100, 16'h0018);
    for (int i = 0; i < 3; i++) begin
      bus(0, 9'h101 + 9'(i), 16'h0000);
      `CHK("group addr", GROUP[16*i +: 16], q)
    end
    boot(GROUP);
    for (int p = 0; p < 2; p++) begin
      remote_boot_en <= p[0];
      foreach (ids[i]) begin
        bus(1, ids[i], 16'($random(seed)));
        bus(0, ids[i], 16'h0000);
        `CHK("id word", exp_word(ids[i]), q)
      end
    end
    addr = 48'({$random(seed), $random(seed)});
    for (int i = 0; i < 3; i++) bus(1, 9'h101 + 9'(i), addr[16*i +: 16]);
    bus(1, 9'h100, 16'h0019);
    for (int i = 0; i < 3; i++) bus(1, 9'h101 + 9'(i), 16'h0000);
    bus(1, 9'h100, 16'h0018);
    for (int i = 0; i < 3; i++) begin
      bus(0, 9'h101 + 9'(i), 16'h0000);
      `CHK("boot addr", addr[16*i +: 16], q)
    end
    boot(addr);
    bus(1, 9'h100, 16'h0119);
    bus(0, 9'h105, 16'h0000);
    `CHK("cmd error", 1'b1, q[0])
    bus(1, 9'h105, 16'h0001);
    bus(0, 9'h105, 16'h0000);
    `CHK("cmd error clear", 1'b0, q[0])
    bus(1, 9'h100, 16'h0020);
    bus(0, 9'h105, 16'h0000);
    `CHK("bad opcode", 1'b1, q[0])
    bus(1, 9'h105, 16'h0001);
    frame(0, 8'h05);
    `CHK("reply tag", tag, u_sid_node_model.words[0])
    frame(1, 8'hc8);
    `CHK("unprompted tag", 16'h0000, u_sid_node_model.words[0])
    results();
  end
endmodule
